/* src/tmr8_consts.svh */
// Register offsets, field positions, reset values and prescaler masks
`ifndef TMR8_CONSTS_SVH
`define TMR8_CONSTS_SVH
`define TMR8_OFF_CTRL 8'h00
`define TMR8_OFF_COUNT 8'h04
`define TMR8_OFF_COMPARE 8'h08
`define TMR8_OFF_FLAGS 8'h0C
`define TMR8_OFF_MASK 8'h10
`define TMR8_OFF_STATUS 8'h14
`define TMR8_CTRL_CS_LSB 0
`define TMR8_CTRL_WGM_LSB 3
`define TMR8_CTRL_COM_LSB 5
`define TMR8_CTRL_FORCE_BIT 7
`define TMR8_FLAG_OVF_BIT 0
`define TMR8_FLAG_CMP_BIT 1
`define TMR8_RST_BYTE 8'h00
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hFF
`define TMR8_DIV8_MASK 10'h007
`define TMR8_DIV64_MASK 10'h03F
`define TMR8_DIV256_MASK 10'h0FF
`define TMR8_DIV1024_MASK 10'h3FF
`endif

/* src/tmr8_pkg.sv */
// Types shared by the timer design
package tmr8_pkg;
  typedef enum logic [1:0]
  {
    WGM_NORMAL,
    WGM_PHASE_PWM,
    WGM_CTC,
    WGM_FAST_PWM
  } tmr8_wgm_t;

  typedef enum logic [2:0]
  {
    CS_STOP,
    CS_DIV1,
    CS_DIV8,
    CS_DIV64,
    CS_DIV256,
    CS_DIV1024,
    CS_EXT_FALL,
    CS_EXT_RISE
  } tmr8_cs_t;

  typedef struct packed
  {
    logic [1:0] com;
    tmr8_wgm_t wgm;
    tmr8_cs_t cs;
  } tmr8_ctrl_t;

  typedef struct packed
  {
    logic valid;
    logic write;
    logic [7:0] addr;
  } tmr8_dphase_t;
endpackage

/* src/tmr8_top.sv */
// 8-bit timer/counter with one compare unit behind an AHB-Lite slave
//
// What this block does
// - Counter value and compare value are both eight bits wide.
// - Tick comes from prescaler or external count pin, source and edge selectable.
// - Clock select zero gives no tick; counter holds its value.
// - Each tick clears, increments or decrements the counter per waveform mode.
// - CPU may read and write the counter at any time.
// - A CPU counter write beats any same-cycle clear or count.
// - Bottom is 0x00, max is 0xFF; top is 0xFF or compare value.
// - Comparator runs always; match sets compare flag on following tick.
// - Compare request only when flag, compare enable and global enable all set.
// - Compare flag clears on service or on software writing one.
// - PWM modes double buffer compare value, loaded at top; else bypassed.
// - CPU compare accesses hit buffer in PWM modes, active register otherwise.
// - Force compare in non-PWM modes acts on output only, no flag, no clear.
// - Counter write blocks any compare match in next tick, even when stopped.
// - Compare output state survives waveform mode changes.
// - Compare output mode changes apply immediately, not buffered.
// - Overflow flag set per mode and usable as an interrupt source.
// - Mode zero counts up, wraps 0xFF to 0x00, overflow as it hits zero.
// - Mode two clears the counter on match; compare value is top.
// - Mode three counts bottom to max and restarts; overflow at max.
`timescale 1ns/1ps
`include "tmr8_consts.svh"

module tmr8_top
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic EXT_COUNT_IN,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic CMP_IRQ_ACK,
  input wire logic OVF_IRQ_ACK,
  output logic CMP_IRQ_REQ,
  output logic OVF_IRQ_REQ,
  output logic COMPARE_OUTPUT,
  output logic COMPARE_OUTPUT_EN
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  // eight-bit registers
  logic [7:0] counter_value_reg, compare_value_reg, compare_buf_reg;
  logic [7:0] counter_next, wbyte;
  tmr8_pkg::tmr8_ctrl_t ctrl_reg;
  tmr8_pkg::tmr8_dphase_t dphase_reg;
  logic [1:0] com_now;
  logic [9:0] presc_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic compare_flag_reg, overflow_flag_reg, compare_output_reg, count_up_reg;
  logic compare_irq_enable_reg, overflow_irq_enable_reg, block_reg, ext_prev_reg;
  logic count_up_next, timer_tick, wr_en, cnt_wr, cmp_wr, ctrl_wr, flag_wr, mask_wr;
  logic addr_ok, is_pwm, match, match_ev, at_bottom, at_max, at_top;
  logic force_ev, ovf_set, reload;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_reg;
  assign addr_ok = HSEL && HTRANS[1] && HREADY;
  assign wr_en = dphase_reg.valid && dphase_reg.write;
  assign wbyte = HWDATA[7:0];
  assign cnt_wr = wr_en && (dphase_reg.addr == `TMR8_OFF_COUNT);
  assign cmp_wr = wr_en && (dphase_reg.addr == `TMR8_OFF_COMPARE);
  assign ctrl_wr = wr_en && (dphase_reg.addr == `TMR8_OFF_CTRL);
  assign flag_wr = wr_en && (dphase_reg.addr == `TMR8_OFF_FLAGS);
  assign mask_wr = wr_en && (dphase_reg.addr == `TMR8_OFF_MASK);

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      dphase_reg <= '0;
    else
      dphase_reg <= '{valid: addr_ok, write: HWRITE, addr: HADDR[7:0]};
  end

  // Read data captured in address phase; unmapped reads give zero
  always_comb
  begin
    rdata_next = 32'h00000000;
    unique case (HADDR[7:0])
      `TMR8_OFF_CTRL: rdata_next[6:0] = ctrl_reg;
      `TMR8_OFF_COUNT: rdata_next[7:0] = counter_value_reg;
      `TMR8_OFF_COMPARE: rdata_next[7:0] = is_pwm ? compare_buf_reg : compare_value_reg;
      `TMR8_OFF_FLAGS:
      begin
        rdata_next[`TMR8_FLAG_OVF_BIT] = overflow_flag_reg;
        rdata_next[`TMR8_FLAG_CMP_BIT] = compare_flag_reg;
      end
      `TMR8_OFF_MASK:
      begin
        rdata_next[`TMR8_FLAG_OVF_BIT] = overflow_irq_enable_reg;
        rdata_next[`TMR8_FLAG_CMP_BIT] = compare_irq_enable_reg;
      end
      `TMR8_OFF_STATUS: rdata_next[3:0] = {count_up_reg, at_max, at_bottom, compare_output_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      rdata_reg <= 32'h00000000;
    else if (addr_ok && !HWRITE)
      rdata_reg <= rdata_next;
  end

  // ----------------------------------------
  // Control and mask registers
  // ----------------------------------------
  // reset to zero; mode bits apply at once
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      ctrl_reg <= '0;
    else if (ctrl_wr)
    begin
      ctrl_reg.cs <= tmr8_pkg::tmr8_cs_t'(wbyte[`TMR8_CTRL_CS_LSB +: 3]);
      ctrl_reg.wgm <= tmr8_pkg::tmr8_wgm_t'(wbyte[`TMR8_CTRL_WGM_LSB +: 2]);
      ctrl_reg.com <= wbyte[`TMR8_CTRL_COM_LSB +: 2];
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      {compare_irq_enable_reg, overflow_irq_enable_reg} <= 2'b00;
    else if (mask_wr)
      {compare_irq_enable_reg, overflow_irq_enable_reg}
        <= {wbyte[`TMR8_FLAG_CMP_BIT], wbyte[`TMR8_FLAG_OVF_BIT]};
  end

  // ----------------------------------------
  // Clock select and prescaler
  // ----------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      {presc_reg, ext_prev_reg} <= 11'h000;
    else
      {presc_reg, ext_prev_reg} <= {presc_reg + 10'h001, EXT_COUNT_IN};
  end

  always_comb
  begin
    unique case (ctrl_reg.cs)
      tmr8_pkg::CS_STOP: timer_tick = 1'b0;
      tmr8_pkg::CS_DIV1: timer_tick = 1'b1;
      tmr8_pkg::CS_DIV8: timer_tick = (presc_reg & `TMR8_DIV8_MASK) == `TMR8_DIV8_MASK;
      tmr8_pkg::CS_DIV64: timer_tick = (presc_reg & `TMR8_DIV64_MASK) == `TMR8_DIV64_MASK;
      tmr8_pkg::CS_DIV256: timer_tick = (presc_reg & `TMR8_DIV256_MASK) == `TMR8_DIV256_MASK;
      tmr8_pkg::CS_DIV1024: timer_tick = presc_reg == `TMR8_DIV1024_MASK;
      tmr8_pkg::CS_EXT_FALL: timer_tick = ext_prev_reg && !EXT_COUNT_IN;
      tmr8_pkg::CS_EXT_RISE: timer_tick = !ext_prev_reg && EXT_COUNT_IN;
    endcase
  end

  // ----------------------------------------
  // Counter unit
  // ----------------------------------------
  // extreme values and top
  assign at_bottom = counter_value_reg == `TMR8_BOTTOM;
  assign at_max = counter_value_reg == `TMR8_MAX;
  assign at_top = (ctrl_reg.wgm == tmr8_pkg::WGM_CTC) ? match : at_max;
  assign is_pwm = (ctrl_reg.wgm == tmr8_pkg::WGM_PHASE_PWM)
               || (ctrl_reg.wgm == tmr8_pkg::WGM_FAST_PWM);
  // continuous compare; blocked after counter write
  assign match = counter_value_reg == compare_value_reg;
  assign match_ev = timer_tick && match && !block_reg;

  // clear, count up or down per mode
  always_comb
  begin
    counter_next = counter_value_reg;
    count_up_next = count_up_reg;
    ovf_set = 1'b0;
    unique case (ctrl_reg.wgm)
      // up only, wraps, overflow at zero
      tmr8_pkg::WGM_NORMAL:
      begin
        counter_next = counter_value_reg + 8'h01;
        ovf_set = at_max;
        count_up_next = 1'b1;
      end
      tmr8_pkg::WGM_CTC:
      begin
        counter_next = match_ev ? `TMR8_BOTTOM : counter_value_reg + 8'h01;
        ovf_set = at_max;
        count_up_next = 1'b1;
      end
      // bottom to max, overflow at max
      tmr8_pkg::WGM_FAST_PWM:
      begin
        counter_next = counter_value_reg + 8'h01;
        ovf_set = counter_value_reg == (`TMR8_MAX - 8'h01);
        count_up_next = 1'b1;
      end
      tmr8_pkg::WGM_PHASE_PWM:
      begin
        if (count_up_reg ? at_max : !at_bottom)
        begin
          counter_next = counter_value_reg - 8'h01;
          count_up_next = 1'b0;
        end
        else
        begin
          counter_next = counter_value_reg + 8'h01;
          count_up_next = 1'b1;
        end
        ovf_set = at_bottom && !count_up_reg;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      counter_value_reg <= `TMR8_RST_BYTE;
      count_up_reg <= 1'b1;
    end
    // CPU write has priority; any time
    else if (cnt_wr)
      counter_value_reg <= wbyte;
    else if (timer_tick)
    begin
      counter_value_reg <= counter_next;
      count_up_reg <= count_up_next;
    end
  end

  // block lasts until the next tick
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      block_reg <= 1'b0;
    else if (cnt_wr)
      block_reg <= 1'b1;
    else if (timer_tick)
      block_reg <= 1'b0;
  end

  // ----------------------------------------
  // Compare register and buffer
  // ----------------------------------------
  // load active copy at top in PWM modes
  assign reload = is_pwm && timer_tick && at_max;

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      compare_value_reg <= `TMR8_RST_BYTE;
      compare_buf_reg <= `TMR8_RST_BYTE;
    end
    else
    begin
      if (cmp_wr)
        compare_buf_reg <= wbyte;
      if (cmp_wr && !is_pwm)
        compare_value_reg <= wbyte;
      else if (reload)
        compare_value_reg <= compare_buf_reg;
    end
  end

  // ----------------------------------------
  // Flags and requests
  // ----------------------------------------
  // set wins over clear
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      compare_flag_reg <= 1'b0;
      overflow_flag_reg <= 1'b0;
    end
    else
    begin
      if (match_ev)
        compare_flag_reg <= 1'b1;
      else if (CMP_IRQ_ACK || (flag_wr && wbyte[`TMR8_FLAG_CMP_BIT]))
        compare_flag_reg <= 1'b0;
      if (timer_tick && ovf_set && !cnt_wr)
        overflow_flag_reg <= 1'b1;
      else if (OVF_IRQ_ACK || (flag_wr && wbyte[`TMR8_FLAG_OVF_BIT]))
        overflow_flag_reg <= 1'b0;
    end
  end

  assign CMP_IRQ_REQ = compare_flag_reg && compare_irq_enable_reg && GLOBAL_IRQ_EN;
  assign OVF_IRQ_REQ = overflow_flag_reg && overflow_irq_enable_reg && GLOBAL_IRQ_EN;

  // ----------------------------------------
  // Compare output
  // ----------------------------------------
  // force acts only in non-PWM modes
  assign force_ev = ctrl_wr && wbyte[`TMR8_CTRL_FORCE_BIT] && !is_pwm;
  assign com_now = ctrl_wr ? wbyte[`TMR8_CTRL_COM_LSB +: 2] : ctrl_reg.com;

  // untouched by mode change; uses current mode bits
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      compare_output_reg <= 1'b0;
    else if (!is_pwm && (match_ev || force_ev))
    begin
      unique case (com_now)
        2'h0: compare_output_reg <= compare_output_reg;
        2'h1: compare_output_reg <= !compare_output_reg;
        2'h2: compare_output_reg <= 1'b0;
        2'h3: compare_output_reg <= 1'b1;
      endcase
    end
    else if (ctrl_reg.wgm == tmr8_pkg::WGM_FAST_PWM && ctrl_reg.com[1] && timer_tick)
    begin
      if (match_ev)
        compare_output_reg <= ctrl_reg.com[0];
      else if (at_top)
        compare_output_reg <= !ctrl_reg.com[0];
    end
    else if (ctrl_reg.wgm == tmr8_pkg::WGM_PHASE_PWM && ctrl_reg.com[1] && match_ev)
      compare_output_reg <= count_up_reg ? ctrl_reg.com[0] : !ctrl_reg.com[0];
  end

  assign COMPARE_OUTPUT = compare_output_reg;
  assign COMPARE_OUTPUT_EN = ctrl_reg.com != 2'h0;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_flag_w1c;
    flag_wr && wbyte[`TMR8_FLAG_CMP_BIT] && !match_ev;
  endsequence
  sequence s_cnt_write;
    cnt_wr ##1 (!cnt_wr && timer_tick);
  endsequence

  AST_STOPPED_HOLDS: assert property (ctrl_reg.cs == tmr8_pkg::CS_STOP && !cnt_wr
    |=> $stable(counter_value_reg)) else $error("Counter moved while stopped");
  AST_CPU_WRITE_WINS: assert property (cnt_wr
    |=> counter_value_reg == $past(wbyte)) else $error("Counter write lost");
  AST_WRITE_BLOCKS: assert property (s_cnt_write ##0 !compare_flag_reg
    |=> !compare_flag_reg) else $error("Match not blocked after counter write");
  AST_MATCH_FLAG: assert property (timer_tick && match && !block_reg
    |=> compare_flag_reg) else $error("Match did not set flag");
  AST_IRQ_GATE: assert property (CMP_IRQ_REQ
    |-> compare_flag_reg && compare_irq_enable_reg && GLOBAL_IRQ_EN)
    else $error("Compare request without cause");
  AST_W1C: assert property (s_flag_w1c |=> !compare_flag_reg)
    else $error("Compare flag not cleared by write");
  AST_NORMAL_WRAP: assert property (timer_tick && ctrl_reg.wgm == tmr8_pkg::WGM_NORMAL
    && at_max && !cnt_wr |=> at_bottom && overflow_flag_reg)
    else $error("Normal wrap or overflow wrong");
  AST_CTC_CLEAR: assert property (ctrl_reg.wgm == tmr8_pkg::WGM_CTC && match_ev
    && !cnt_wr |=> at_bottom) else $error("CTC did not clear on match");
  AST_BUF_HOLD: assert property (is_pwm && !reload ##1 is_pwm
    |-> $stable(compare_value_reg)) else $error("Active compare changed outside top");
  AST_FORCE_NO_FLAG: assert property (force_ev && !match_ev && !compare_flag_reg
    |=> !compare_flag_reg && counter_value_reg == $past(counter_value_reg)
    + {7'h00, $past(timer_tick)}) else $error("Force disturbed flag or counter");

endmodule

/* verif/timer8_single_compare_tb.sv */
// Self-checking bench for the 8-bit timer with one compare unit
`timescale 1ns/1ps
`include "tmr8_consts.svh"

module timer8_single_compare_tb;
  logic core_clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, ack, half;
  logic [2:0] hsize;
  logic ext_pin, gie, cmp_req, ovf_req, oc, oc_en, start, busy, svc_en, prev;
  logic [7:0] pulses, st, cm;
  logic [9:0] ex;
  int err_total, checks_done, n, ctc;
  logic [7:0] t_st[3] = '{8'hFE, 8'h40, 8'h00};
  logic [7:0] t_cm[3] = '{8'h00, 8'h40, 8'h03};
  int t_n[3] = '{3, 1, 5};
  int t_ctc[3] = '{0, 0, 1};
  int t_sh[5] = '{0, 3, 6, 8, 10};

  assign hready = hreadyout;

  tmr8_top dut
  (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .EXT_COUNT_IN(ext_pin), .GLOBAL_IRQ_EN(gie),
    .CMP_IRQ_ACK(ack[1]), .OVF_IRQ_ACK(ack[0]), .CMP_IRQ_REQ(cmp_req),
    .OVF_IRQ_REQ(ovf_req), .COMPARE_OUTPUT(oc), .COMPARE_OUTPUT_EN(oc_en)
  );

  tmr8_peer peer
  (
    .clk(core_clk), .rst(sys_rst), .start(start), .pulses(pulses), .half(half),
    .svc_en(svc_en), .req({cmp_req, ovf_req}), .pin(ext_pin), .busy(busy), .ack(ack)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Compare and bus tasks
  // ----------------------------------------
  task automatic check_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic check_pin(input string nm, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %b, seen %b", nm, exp, got);
    end
  endtask

  task automatic check_near(input string nm, input logic [7:0] exp, input logic [7:0] got);
    logic [7:0] d;
    checks_done++;
    d = got - exp;
    if ($isunknown(got) || d > 8'h04)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_rdy;
    @(posedge core_clk);
    while (hready !== 1'b1)
      @(posedge core_clk);
  endtask

  task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr_en;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= {24'hFFFFFF, d};
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    check_val(nm, {24'h000000, exp}, q);
  endtask

  task automatic pulse(input int cnt);
    @(posedge core_clk);
    pulses <= cnt[7:0];
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    do
      @(posedge core_clk);
    while (busy !== 1'b0);
    repeat (3) @(posedge core_clk);
  endtask

  task automatic arm(input logic [7:0] c, input logic [7:0] cmp);
    wr(`TMR8_OFF_CTRL, 8'h00);
    wr(`TMR8_OFF_FLAGS, 8'h03);
    wr(`TMR8_OFF_COMPARE, cmp);
    wr(`TMR8_OFF_COUNT, c);
  endtask

  function automatic logic [7:0] ctl(input logic [2:0] cs, input logic [1:0] wgm,
                                     input logic [1:0] com, input logic frc);
    return {frc, com, wgm, cs};
  endfunction

  // Ticks of normal or clear-on-match mode after a counter write
  function automatic logic [9:0] run(input logic [7:0] c, input logic [7:0] cmp,
                                     input int cnt, input int clr);
    logic blk, fo, fc, m;
    blk = 1'b1;
    fo = 1'b0;
    fc = 1'b0;
    for (int i = 0; i < cnt; i++)
    begin
      m = (c == cmp) && !blk;
      fo = fo | (c == 8'hFF);
      fc = fc | m;
      c = (clr != 0 && m) ? 8'h00 : c + 8'h01;
      blk = 1'b0;
    end
    return {fc, fo, c};
  endfunction

  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #(100 * 60000);
    err_total++;
    test_done();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {sys_rst, hsize} = {1'b1, 3'h2};
    {hsel, haddr, htrans, hwrite, hwdata, gie, start, pulses, half, svc_en} = '0;
    {err_total, checks_done} = '0;
    void'($urandom(32'h2916D58A));
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_chk("ctrl", `TMR8_OFF_CTRL, 8'h00);
    rd_chk("count", `TMR8_OFF_COUNT, 8'h00);
    rd_chk("compare", `TMR8_OFF_COMPARE, 8'h00);
    rd_chk("flags", `TMR8_OFF_FLAGS, 8'h00);
    rd_chk("status", `TMR8_OFF_STATUS, 8'h0A);
    rd_chk("unmapped", 8'h18, 8'h00);
    check_pin("hresp", 1'b0, hresp);
    $display("test reset done");
    repeat (4)
    begin
      st = 8'($urandom);
      wr(`TMR8_OFF_COMPARE, ~st);
      wr(`TMR8_OFF_COUNT, st);
      pulse(3);
      rd_chk("held count", `TMR8_OFF_COUNT, st);
      rd_chk("compare", `TMR8_OFF_COMPARE, ~st);
    end
    $display("test access done");
    for (int i = 0; i < 24; i++)
    begin
      st = (i < 3) ? t_st[i] : 8'($urandom);
      cm = (i < 3) ? t_cm[i] : 8'($urandom);
      n = (i < 3) ? t_n[i] : 1 + $urandom % 40;
      ctc = (i < 3) ? t_ctc[i] : $urandom % 2;
      if (i >= 3 && st == cm)
        cm = cm + 8'h01;
      arm(st, cm);
      wr(`TMR8_OFF_CTRL, ctl((i % 2) ? 3'h6 : 3'h7, (ctc != 0) ? 2'h2 : 2'h0, 2'h0, 1'b0));
      half <= 2'($urandom);
      pulse(n);
      ex = run(st, cm, n, ctc);
      rd_chk("count", `TMR8_OFF_COUNT, ex[7:0]);
      rd_chk("flags", `TMR8_OFF_FLAGS, {6'h00, ex[9:8]});
    end
    $display("test counting done");
    arm(8'hFE, 8'h00);
    wr(`TMR8_OFF_CTRL, ctl(3'h7, 2'h0, 2'h0, 1'b0));
    pulse(3);
    wr(`TMR8_OFF_FLAGS, 8'h01);
    rd_chk("flags", `TMR8_OFF_FLAGS, 8'h02);
    wr(`TMR8_OFF_MASK, 8'h03);
    @(negedge core_clk);
    check_pin("cmp req", 1'b0, cmp_req);
    @(posedge core_clk);
    gie <= 1'b1;
    @(negedge core_clk);
    check_pin("cmp req", 1'b1, cmp_req);
    check_pin("ovf req", 1'b0, ovf_req);
    @(posedge core_clk);
    svc_en <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd_chk("flags", `TMR8_OFF_FLAGS, 8'h00);
    svc_en <= 1'b0;
    arm(8'hFF, 8'h00);
    wr(`TMR8_OFF_CTRL, ctl(3'h7, 2'h0, 2'h0, 1'b0));
    pulse(1);
    @(negedge core_clk);
    check_pin("ovf req", 1'b1, ovf_req);
    $display("test flags done");
    arm(8'hFD, 8'h80);
    wr(`TMR8_OFF_CTRL, ctl(3'h7, 2'h3, 2'h0, 1'b0));
    pulse(2);
    rd_chk("count", `TMR8_OFF_COUNT, 8'hFF);
    rd_chk("flags", `TMR8_OFF_FLAGS, 8'h01);
    rd_chk("status", `TMR8_OFF_STATUS, 8'h0C);
    wr(`TMR8_OFF_COMPARE, 8'h05);
    pulse(1);
    wr(`TMR8_OFF_FLAGS, 8'h03);
    wr(`TMR8_OFF_COMPARE, 8'h02);
    pulse(3);
    rd_chk("flags", `TMR8_OFF_FLAGS, 8'h00);
    rd_chk("compare", `TMR8_OFF_COMPARE, 8'h02);
    $display("test pwm done");
    wr(`TMR8_OFF_CTRL, ctl(3'h0, 2'h0, 2'h1, 1'b0));
    @(negedge core_clk);
    prev = oc;
    check_pin("oc enable", 1'b1, oc_en);
    wr(`TMR8_OFF_CTRL, ctl(3'h0, 2'h0, 2'h1, 1'b1));
    @(negedge core_clk);
    check_pin("oc forced", ~prev, oc);
    rd_chk("flags", `TMR8_OFF_FLAGS, 8'h00);
    rd_chk("count", `TMR8_OFF_COUNT, 8'h03);
    wr(`TMR8_OFF_CTRL, ctl(3'h0, 2'h2, 2'h1, 1'b0));
    @(negedge core_clk);
    check_pin("oc kept", ~prev, oc);
    wr(`TMR8_OFF_CTRL, ctl(3'h0, 2'h2, 2'h3, 1'b1));
    wr(`TMR8_OFF_CTRL, ctl(3'h0, 2'h0, 2'h0, 1'b0));
    @(negedge core_clk);
    check_pin("oc enable", 1'b0, oc_en);
    check_pin("oc set", 1'b1, oc);
    $display("test force done");
    // Counter write while running at full rate onto the compare value
    wr(`TMR8_OFF_COMPARE, 8'h60);
    wr(`TMR8_OFF_FLAGS, 8'h03);
    wr(`TMR8_OFF_CTRL, ctl(3'h1, 2'h0, 2'h0, 1'b0));
    wr(`TMR8_OFF_COUNT, 8'h60);
    wr(`TMR8_OFF_CTRL, 8'h00);
    rd_chk("flags", `TMR8_OFF_FLAGS, 8'h00);
    rd_chk("count", `TMR8_OFF_COUNT, 8'h63);
    $display("test blocking done");
    for (int k = 1; k < 6; k++)
    begin
      wr(`TMR8_OFF_CTRL, 8'h00);
      wr(`TMR8_OFF_COUNT, 8'h00);
      wr(`TMR8_OFF_CTRL, ctl(k[2:0], 2'h0, 2'h0, 1'b0));
      repeat (1800) @(posedge core_clk);
      wr(`TMR8_OFF_CTRL, 8'h00);
      xfer(1'b0, `TMR8_OFF_COUNT, 8'h00);
      check_near("prescaled count", 8'(1800 >> t_sh[k - 1]), q[7:0]);
    end
    $display("test prescaler done");
    test_done();
  end
endmodule

/* verif/tmr8_peer.sv */
// Far-side model: external count pin source and interrupt servicing CPU
`timescale 1ns/1ps

module tmr8_peer
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] pulses,
  input wire logic [1:0] half,
  input wire logic svc_en,
  input wire logic [1:0] req,
  output logic pin,
  output logic busy,
  output logic [1:0] ack
);
  logic [8:0] left_reg;
  logic [1:0] wait_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin <= 1'b0;
      busy <= 1'b0;
      left_reg <= 9'h000;
      wait_reg <= 2'h0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      left_reg <= {pulses, 1'b0};
      wait_reg <= half;
    end
    else if (busy)
    begin
      if (wait_reg != 2'h0)
        wait_reg <= wait_reg - 2'h1;
      else if (left_reg == 9'h000)
        busy <= 1'b0;
      else
      begin
        pin <= ~pin;
        left_reg <= left_reg - 9'h001;
        wait_reg <= half;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ack <= 2'h0;
    else
      ack <= req & ~ack & {2{svc_en}};
  end
endmodule
